//--- disk_channel_op_decoder.sv
// channel operation decoder of the disk adapter
//
// Contract
// (R1) top bits 10 decode as seek
// (R2) head leading 1 fixed select, else moving
// (R3) seek head/cylinder kept in seek register
// (R4) moving seek: fetch next op immediately
// (R5) during moving seek bar seek/recal/xfer/end
// (R6) fixed head since seek allows data transfer
// (R7) top bits 11 only load seek register
// (R8) no-op just fetches next operation
// (R9) 23 unimplemented upper bytes act as no-op
// (R10) PCI sets status and pending interrupt
// (R11) load burst from low three bits
// (R12) load skip factor and residual count
// (R13) field count is fields minus one
// (R14) load control or data vector from operand
// (R15) operand into control pointer bytes 2-3
// (R16) operand into data pointer bytes 0-1
// (R17) list must avoid maintenance code ranges
// (R18) transfer op: code, sector, first field
// (R19) head/cylinder mismatch flags identifier error
// (R20) read ID at sector, send to storage
// (R21) displaced: use next sector's identifier
// (R22) unrecovered check error: read error, no data
// (R23) end op clears busy, raises request
// (R24) control vector fetches ops, data vector data
// (R25) barred operation held until seek ends
// (R26) trailing operand fetched in next burst
`include "disk_op_regs.svh"
`timescale 1ns/100ps
module disk_channel_op_decoder
    import disk_op_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [15:0] start_vector,
    input  wire logic        op_valid,
    input  wire logic [15:0] op_data,
    output logic             op_ready,
    output logic             fetch_req,
    output logic [15:0]      fetch_vector,
    input  wire logic        seek_busy,
    output logic             seek_start,
    output logic             fixed_head_sel,
    output logic [15:0]      seek_reg,
    output logic [2:0]       burst_len,
    output logic [1:0]       skip_factor,
    output logic [5:0]       residual_count,
    output logic [6:0]       field_total,
    output logic [5:0]       selected_sector_holder,
    output logic             first_field,
    output ptr_wr_t          ptr_wr,
    output logic [15:0]      data_vector,
    input  wire logic        enable,
    input  wire logic [15:0] status_clr,
    output logic [15:0]      adapter_status_word,
    output logic             irq,
    input  wire logic [5:0]  rotating_sector_position,
    output logic             id_rd_req,
    input  wire logic        id_valid,
    input  wire id_field_t   id_field,
    input  wire logic        id_crc_err,
    input  wire logic        id_recovered,
    output logic             xfer_valid,
    output logic [15:0]      xfer_data,
    input  wire logic        xfer_ready
);

    dec_state_t  s_ff;
    dec_state_t  nxt_s;
    logic [7:0]  ub;
    logic        moving;
    logic        barred_xfer;
    logic        push_valid;
    logic [15:0] push_data;
    logic        push_ready;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_nop(input logic [7:0] code);
        logic r;
        r = 1'b0;
        unique case (code) inside
            8'h08, 8'h0b, [8'h0c:8'h0f], 8'h40, 8'h41, 8'h43,
            [8'h44:8'h47], [8'h54:8'h56], [8'h58:8'h5f]: r = 1'b1;
            default:                                     r = 1'b0;
        endcase
        return r;
    endfunction : is_nop

    function automatic dec_state_t to_fetch(input dec_state_t x);
        dec_state_t y;
        y           = x;
        y.st        = ST_FETCH;
        y.fetch_req = 1'b1;
        y.op_ready  = 1'b1;
        return y;
    endfunction : to_fetch

    // ends the channel operation, raising the given status bits
    function automatic dec_state_t finish(input dec_state_t x,
                                          input logic [15:0] bits);
        dec_state_t y;
        y = x;
        y.stat = x.stat | bits;
        y.stat[`ST_IRQ] = 1'b1;
        y.stat[`ST_BUSY] = 1'b0;
        y.st = ST_IDLE;
        y.fetch_req = 1'b0;
        y.op_ready = 1'b0;
        y.id_rd = 1'b0;
        return y;
    endfunction : finish

    ////////////////////////////////////////////////////////////////////////
    // next state

    // arm must raise seek_busy within one cycle of seek_start
    assign moving      = s_ff.seek_start | seek_busy;
    assign barred_xfer = moving & ~s_ff.fixed_since;
    assign ub          = s_ff.op[15:8];

    always_comb begin
        nxt_s = s_ff;
        nxt_s.seek_start = 1'b0;
        nxt_s.ptr.valid = 1'b0;
        push_valid = 1'b0;
        push_data = 16'h0000;
        // software clears status bits; a set below in the same cycle wins
        nxt_s.stat          = s_ff.stat & ~status_clr;
        nxt_s.stat[`ST_ENABLED] = enable;
        unique case (s_ff.st)
            ST_IDLE: begin
                if (start) begin
                    nxt_s.ctrl_vec         = start_vector;
                    nxt_s.stat[`ST_BUSY]   = 1'b1;
                    nxt_s                  = to_fetch(nxt_s);
                end
            end
            ST_FETCH: begin
                if (op_valid) begin
                    nxt_s.op        = op_data;
                    nxt_s.fetch_req = 1'b0;
                    nxt_s.op_ready  = 1'b0;
                    nxt_s.st        = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (s_ff.op[15:14] == `CODE_SEEK) begin // R1
                    if (s_ff.op[`SEEK_FIXED_BIT]) begin // R2
                        nxt_s.seek[13:0]  = s_ff.op[13:0]; // R3
                        nxt_s.fixed_sel   = 1'b1;
                        nxt_s.fixed_since = 1'b1; // R6
                        nxt_s             = to_fetch(nxt_s);
                    end else if (moving) begin
                        nxt_s.st = ST_HOLD; // R5
                    end else begin
                        nxt_s.seek[13:0]  = s_ff.op[13:0]; // R3
                        nxt_s.seek_start  = 1'b1; // R2
                        nxt_s.fixed_sel   = 1'b0;
                        nxt_s.fixed_since = 1'b0;
                        nxt_s             = to_fetch(nxt_s); // R4
                    end
                end else if (s_ff.op[15:14] == `CODE_LDSEEK) begin
                    nxt_s.seek[13:0] = s_ff.op[13:0]; // R7
                    nxt_s            = to_fetch(nxt_s);
                end else if (is_nop(ub)) begin
                    nxt_s = to_fetch(nxt_s); // R8 R9
                end else begin
                    unique case (ub)
                        `UB_END0, `UB_END1: begin
                            if (moving) begin
                                nxt_s.st = ST_HOLD; // R5 R25
                            end else begin
                                nxt_s = finish(nxt_s, 16'h0000); // R23
                            end
                        end
                        `UB_PCI: begin
                            nxt_s.stat[`ST_PCI] = 1'b1; // R10
                            nxt_s.stat[`ST_IRQ] = 1'b1; // R10
                            nxt_s               = to_fetch(nxt_s);
                        end
                        `UB_BURST: begin
                            nxt_s.burst = s_ff.op[2:0]; // R11
                            nxt_s       = to_fetch(nxt_s);
                        end
                        `UB_SKIP: begin
                            nxt_s.skip   = s_ff.op[7:6]; // R12
                            nxt_s.resid  = s_ff.op[5:0]; // R12
                            nxt_s.fields = {1'b0, s_ff.op[5:0]} + 7'd1; // R13
                            nxt_s        = to_fetch(nxt_s);
                        end
                        `UB_LD_CV, `UB_LD_DV, `UB_LD_CP, `UB_LD_DP: begin
                            nxt_s.st        = ST_OPND; // R26
                            nxt_s.fetch_req = 1'b1;
                            nxt_s.op_ready  = 1'b1;
                        end
                        `UB_RECAL: begin
                            // arm recalibration lives outside this block
                            if (moving) begin
                                nxt_s.st = ST_HOLD; // R5
                            end else begin
                                nxt_s = to_fetch(nxt_s);
                            end
                        end
                        `UB_RD_ID: begin
                            if (barred_xfer) begin
                                nxt_s.st = ST_HOLD; // R5 R6 R25
                            end else begin
                                nxt_s.sector = s_ff.op[6:1]; // R18
                                nxt_s.field  = s_ff.op[0]; // R18
                                nxt_s.disp   = 1'b0;
                                nxt_s.st     = ST_ID_WAIT;
                            end
                        end
                        default: begin
                            // undefined and maintenance codes: stop the list
                            nxt_s = finish(nxt_s, 16'h0000 |
                                (16'h0001 << `ST_DEVERR)); // R17
                        end
                    endcase
                end
            end
            ST_OPND: begin
                if (op_valid) begin
                    unique case (ub)
                        `UB_LD_CV: nxt_s.ctrl_vec = op_data; // R14
                        `UB_LD_DV: nxt_s.data_vec = op_data; // R14
                        `UB_LD_CP: begin
                            nxt_s.ptr = {1'b1, s_ff.ctrl_vec, 1'b0,
                                         op_data}; // R15
                        end
                        `UB_LD_DP: begin
                            nxt_s.ptr = {1'b1, s_ff.data_vec, 1'b1,
                                         op_data}; // R16
                        end
                        default: begin
                        end
                    endcase
                    nxt_s = to_fetch(nxt_s); // R26
                end
            end
            ST_HOLD: begin
                // the held op is decoded again, not dropped
                if (!moving) begin
                    nxt_s.st = ST_EXEC; // R25
                end
            end
            ST_ID_WAIT: begin
                if (rotating_sector_position == s_ff.sector) begin // R20
                    nxt_s.id_rd = 1'b1;
                    nxt_s.st    = ST_ID_READ;
                end
            end
            ST_ID_READ: begin
                if (id_valid) begin
                    if (id_crc_err && !id_recovered) begin
                        nxt_s = finish(nxt_s,
                            (16'h0001 << `ST_READERR) |
                            (16'h0001 << `ST_IDERR) |
                            (16'h0001 << `ST_DEVERR)); // R22
                    end else if (id_field.flag[`FLAG_DISP_BIT] &&
                                 !s_ff.disp) begin
                        // keep reading: the next identifier is the one
                        nxt_s.disp = 1'b1; // R21
                    end else if (s_ff.disp &&
                                 id_field.sector[5:0] != s_ff.sector) begin
                        nxt_s = finish(nxt_s,
                            (16'h0001 << `ST_SNF) |
                            (16'h0001 << `ST_DEVERR)); // R21
                    end else if (id_field.headcyl[13:0] !=
                                 s_ff.seek[13:0]) begin
                        nxt_s = finish(nxt_s,
                            (16'h0001 << `ST_IDERR) |
                            (16'h0001 << `ST_DEVERR)); // R19
                    end else begin
                        nxt_s.id      = id_field; // R20
                        nxt_s.id_rd   = 1'b0;
                        nxt_s.push_lo = 1'b0;
                        nxt_s.st      = ST_ID_PUSH;
                    end
                end
            end
            ST_ID_PUSH: begin
                // upper halfword first; a full FIFO stalls here
                push_valid = 1'b1;
                push_data  = s_ff.push_lo ? s_ff.id[15:0] : s_ff.id[31:16];
                if (push_ready) begin
                    if (s_ff.push_lo) begin
                        nxt_s = to_fetch(nxt_s); // R20
                    end else begin
                        nxt_s.push_lo = 1'b1;
                    end
                end
            end
        endcase
        // a request held while disabled goes out once enabled
        nxt_s.irq = nxt_s.stat[`ST_IRQ] & enable; // R10 R23
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff      <= '0;
            s_ff.st   <= ST_IDLE;
            s_ff.stat <= `STAT_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // identifier words toward storage

    op_fifo #(
        .W     (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (push_valid),
        .in_data   (push_data),
        .in_ready  (push_ready),
        .out_valid (xfer_valid),
        .out_data  (xfer_data),
        .out_ready (xfer_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign op_ready = s_ff.op_ready;
    assign fetch_req = s_ff.fetch_req;
    assign fetch_vector = s_ff.ctrl_vec; // R24
    assign data_vector = s_ff.data_vec; // R24
    assign seek_start = s_ff.seek_start;
    assign fixed_head_sel = s_ff.fixed_sel;
    assign seek_reg = s_ff.seek;
    assign burst_len = s_ff.burst;
    assign skip_factor = s_ff.skip;
    assign residual_count = s_ff.resid;
    assign field_total = s_ff.fields;
    assign selected_sector_holder = s_ff.sector;
    assign first_field = s_ff.field;
    assign ptr_wr = s_ff.ptr;
    assign adapter_status_word = s_ff.stat;
    assign irq = s_ff.irq;
    assign id_rd_req = s_ff.id_rd;

endmodule : disk_channel_op_decoder

//--- disk_op_regs.svh
// constants of the channel operation decoder: codes, bit positions, sizes
`ifndef DISK_OP_REGS_SVH
`define DISK_OP_REGS_SVH

// data path sizes
`define OP_W            16
`define FIFO_DEPTH      16

// top two bits of an operation, and the seek fixed-head bit
`define CODE_SEEK       2'b10
`define CODE_LDSEEK     2'b11
`define SEEK_FIXED_BIT  13

// upper-byte operation codes
`define UB_END0         8'h00
`define UB_END1         8'h10
`define UB_NOP          8'h08
`define UB_PCI          8'h09
`define UB_BURST        8'h0a
`define UB_SKIP         8'h18
`define UB_LD_CV        8'h50
`define UB_LD_DV        8'h51
`define UB_LD_CP        8'h52
`define UB_LD_DP        8'h57
`define UB_RECAL        8'h42
`define UB_RD_ID        8'h20

// status word bit indices (index 0 is bit 0 of the word)
`define ST_READERR      13
`define ST_IDERR        12
`define ST_SNF          10
`define ST_DEVERR       6
`define ST_PCI          7
`define ST_BUSY         4
`define ST_ENABLED      1
`define ST_IRQ          0
`define STAT_RST        16'h0000

// identifier flag byte: sector displaced
`define FLAG_DISP_BIT   3

`endif

//--- disk_op_pkg.sv
// types shared by the channel operation decoder
package disk_op_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_EXEC, ST_OPND,
        ST_HOLD, ST_ID_WAIT, ST_ID_READ, ST_ID_PUSH
    } state_t;

    typedef struct packed {
        logic [7:0]  flag;
        logic [7:0]  sector;
        logic [15:0] headcyl;
    } id_field_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
        logic        upper;
        logic [15:0] addr;
    } ptr_wr_t;

    typedef struct packed {
        state_t      st;
        logic [15:0] op;
        logic [15:0] ctrl_vec;
        logic [15:0] data_vec;
        logic [15:0] seek;
        logic [15:0] stat;
        logic [2:0]  burst;
        logic [1:0]  skip;
        logic [5:0]  resid;
        logic [6:0]  fields;
        logic [5:0]  sector;
        logic        field;
        logic        fixed_since;
        logic        disp;
        logic        push_lo;
        id_field_t   id;
        logic        fetch_req;
        logic        op_ready;
        logic        seek_start;
        logic        fixed_sel;
        logic        id_rd;
        logic        irq;
        ptr_wr_t     ptr;
    } dec_state_t;

endpackage : disk_op_pkg

//--- op_fifo.sv
// word FIFO with a registered output stage
`timescale 1ns/100ps
module op_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    ov;
        logic [W-1:0]            od;
    } fifo_t;

    fifo_t s_ff;
    fifo_t nxt_s;
    logic  push;
    logic  pop;

    ////////////////////////////////////////////////////////////////////////
    // depth must be a power of two: pointers wrap by overflow
    always_comb begin
        nxt_s    = s_ff;
        in_ready = (s_ff.cnt != CW'(DEPTH));
        push     = in_valid & in_ready;
        pop      = (s_ff.cnt != '0) & (~s_ff.ov | out_ready);
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data;
            nxt_s.wp           = s_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_s.od = s_ff.mem[s_ff.rp];
            nxt_s.ov = 1'b1;
            nxt_s.rp = s_ff.rp + 1'b1;
        end else if (out_ready) begin
            nxt_s.ov = 1'b0;
        end
        if (push && !pop) begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_s.cnt = s_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign out_valid = s_ff.ov;
    assign out_data  = s_ff.od;

endmodule : op_fifo

//--- disk_op_properties.sv
// concurrent checks on the ports of the channel operation decoder
`include "disk_op_regs.svh"
`timescale 1ns/100ps
module disk_op_properties
    import disk_op_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        seek_busy,
    input wire logic        seek_start,
    input wire logic        fixed_head_sel,
    input wire logic [15:0] seek_reg,
    input wire logic [5:0]  residual_count,
    input wire logic [6:0]  field_total,
    input wire ptr_wr_t     ptr_wr,
    input wire logic [15:0] fetch_vector,
    input wire logic [15:0] data_vector,
    input wire logic        enable,
    input wire logic [15:0] adapter_status_word,
    input wire logic        irq,
    input wire logic        xfer_valid,
    input wire logic [15:0] xfer_data,
    input wire logic        xfer_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    seek_free_a: assert property (seek_start |-> !$past(seek_busy))
        else $error("seek during arm motion");
    fixed_quiet_a: assert property ($rose(fixed_head_sel) |-> !seek_start)
        else $error("fixed select moved arm");
    seek_fields_a: assert property (seek_start |-> seek_reg[15:13] == 3'h0)
        else $error("bad seek register");
    pci_req_a: assert property ($rose(adapter_status_word[`ST_PCI])
        |-> adapter_status_word[`ST_IRQ])
        else $error("PCI without request");
    // irq follows the request bit one cycle after enable was sampled
    irq_raise_a: assert property (enable
        |=> irq == adapter_status_word[`ST_IRQ])
        else $error("request not presented");
    end_done_a: assert property ($fell(adapter_status_word[`ST_BUSY])
        |-> adapter_status_word[`ST_IRQ])
        else $error("end without request");
    end_still_a: assert property ($fell(adapter_status_word[`ST_BUSY])
        && !adapter_status_word[`ST_DEVERR] |-> !$past(seek_busy))
        else $error("end during arm motion");
    count_plus_a: assert property ($changed(residual_count) |-> ##[0:1]
        field_total == {1'b0, residual_count} + 7'h01)
        else $error("field total not count+1");
    ptr_vec_a: assert property (ptr_wr.valid |-> ptr_wr.vector ==
        (ptr_wr.upper ? data_vector : fetch_vector))
        else $error("pointer write wrong vector");
    xfer_hold_a: assert property (xfer_valid && !xfer_ready
        |=> xfer_valid && $stable(xfer_data))
        else $error("stalled word changed");
endmodule : disk_op_properties

bind disk_channel_op_decoder disk_op_properties u_disk_op_properties (.*);

//--- channel_model.sv
// channel side model: hands out the operation list on request
`timescale 1ns/100ps
module channel_model (
    input  wire logic   sys_clk,
    input  wire logic   rstn,
    input  wire logic   fetch_req,
    input  wire logic   op_ready,
    output logic        op_valid = 1'b0,
    output logic [15:0] op_data = 16'h0000
);
    logic [15:0] list_q[$];
    int          lag = 0;
    int          wait_n = 0;

    // lists never carry maintenance codes
    task automatic push(input logic [15:0] w);
        list_q.push_back(w);
    endtask : push

    always @(posedge sys_clk) begin : serve
        logic taken;
        taken = op_valid && op_ready;
        #1;
        if (!rstn) begin
            op_valid = 1'b0;
        end else if (taken) begin
            void'(list_q.pop_front());
            op_valid = 1'b0;
            // a released line shows the inverse, never the stale word
            op_data  = ~op_data;
            wait_n   = lag;
        end else if (!op_valid && fetch_req && list_q.size() > 0) begin
            if (wait_n > 0) begin
                wait_n--;
            end else begin
                op_valid = 1'b1;
                op_data  = list_q[0];
            end
        end
    end
endmodule : channel_model

//--- tb.sv
// self-checking bench of the channel operation decoder
`include "disk_op_regs.svh"
`timescale 1ns/100ps
module tb;
    import disk_op_pkg::*;
    logic        sys_clk = 1'b0, rstn = 1'b0, start = 1'b0, enable = 1'b0;
    logic        seek_busy = 1'b0, id_valid = 1'b0, id_crc_err = 1'b0;
    logic        id_recovered = 1'b0, xfer_ready = 1'b1, stutter = 1'b0;
    logic [15:0] start_vector = 16'h0000, status_clr = 16'h0000;
    logic [5:0]  rotating_sector_position = 6'h00;
    id_field_t   id_field = '0;
    logic        op_valid, op_ready, fetch_req, seek_start, fixed_head_sel;
    logic        first_field, id_rd_req, xfer_valid, irq;
    logic [15:0] op_data, fetch_vector, seek_reg, data_vector, xfer_data;
    logic [15:0] adapter_status_word;
    logic [2:0]  burst_len;
    logic [1:0]  skip_factor;
    logic [5:0]  residual_count, selected_sector_holder;
    logic [6:0]  field_total;
    ptr_wr_t     ptr_wr, ptr_seen[2];
    logic [15:0] words[$];
    logic [33:0] ids[$];
    int          mismatches = 0, n_tests = 0, cyc = 0, n_seek = 0, arm = 0;
    logic [33:0] id_a[5] = '{34'h0_0005_207e, 34'h2_0005_207f,
                             34'h0_0805_207f, 34'h3_0005_207f, 34'h0_0805_207f};
    logic [33:0] id_b[5] = '{34'h0, 34'h0, 34'h0_0006_207f, 34'h0,
                             34'h0_0005_207f};
    logic [15:0] st_e[5] = '{16'h1043, 16'h3043, 16'h0443, 16'h0003, 16'h0003};
    logic [4:0]  nw_e[5] = '{5'h00, 5'h00, 5'h00, 5'h02, 5'h02};

    disk_channel_op_decoder u_disk_channel_op_decoder (.*);
    channel_model u_channel_model (.*);

    always #20 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    // arm, disk and stream partners; the arm stays busy for 30 cycles
    always @(posedge sys_clk) begin
        if (xfer_valid && xfer_ready) words.push_back(xfer_data);
        if (ptr_wr.valid) ptr_seen[ptr_wr.upper] = ptr_wr;
        #1;
        cyc++;
        rotating_sector_position++;
        if (stutter) xfer_ready = cyc[0];
        if (seek_start) begin
            n_seek++;
            arm = 30;
        end else if (arm > 0) arm--;
        seek_busy = arm > 0;
        if (id_valid) id_valid = 1'b0;
        else if (id_rd_req && ids.size() > 0)
            {id_valid, id_crc_err, id_recovered, id_field} =
                {1'b1, ids.pop_front()};
        if (cyc == 6000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic put(input logic [15:0] lst[$]);
        foreach (lst[i]) u_channel_model.push(lst[i]);
    endtask : put

    task automatic launch(input logic [15:0] vec);
        status_clr = 16'hffff;
        tick(1);
        status_clr = 16'h0000;
        start = 1'b1;
        start_vector = vec;
        tick(1);
        start = 1'b0;
        tick(1);
    endtask : launch

    task automatic settle;
        for (int n = 0; n < 3000 && adapter_status_word[`ST_BUSY] !== 1'b0; n++)
            tick(1);
        tick(40);
    endtask : settle

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    initial begin
        tick(5);
        rstn = 1'b1;
        // control loads and every unused code, request masked
        put('{16'h0a05, 16'h18ff, 16'h0800});
        for (int b = 0; b < 256; b++)
            if (b[7:0] inside {8'h0b, [8'h0c:8'h0f], 8'h40, 8'h41, 8'h43,
                    [8'h44:8'h47], [8'h54:8'h56], [8'h58:8'h5f]})
                u_channel_model.push({b[7:0], 8'hff});
        put('{16'h0900, 16'h5000, 16'h1234, 16'h5100, 16'h4321, 16'h5200,
              16'habcd, 16'h5700, 16'hdcba, 16'h1000});
        launch(16'h0777);
        settle;
        chk(burst_len, 3'h5);
        chk({skip_factor, residual_count, field_total}, 15'h7fc0);
        chk({fetch_vector, data_vector}, 32'h1234_4321);
        chk(ptr_seen[0], {1'b1, 16'h1234, 1'b0, 16'habcd});
        chk(ptr_seen[1], {1'b1, 16'h4321, 1'b1, 16'hdcba});
        chk({adapter_status_word, irq}, 17'h00102);
        enable = 1'b1;
        tick(3);
        chk(irq, 1'b1);
        // slow channel; barred operations wait for the arm
        u_channel_model.lag = 2;
        put('{16'h8123, 16'h0a03, 16'h8045, 16'hc2a5, 16'h0000});
        launch(16'h0100);
        tick(15);
        chk({adapter_status_word[`ST_BUSY], burst_len, n_seek[1:0]}, 6'h2d);
        settle;
        chk({fixed_head_sel, seek_reg, n_seek[1:0]}, 19'h00a96);
        chk(adapter_status_word, 16'h0003);
        u_channel_model.lag = 0;
        // nine identifier reads into a stalled stream
        xfer_ready = 1'b0;
        put('{16'ha07f});
        repeat (9) begin
            u_channel_model.push(16'h200b);
            ids.push_back(34'h0_0005_207f);
        end
        u_channel_model.push(16'h0000);
        launch(16'h0100);
        tick(900);
        chk({adapter_status_word[`ST_BUSY], xfer_valid, fixed_head_sel,
             first_field, selected_sector_holder}, 10'h3c5);
        chk(words.size(), 0);
        stutter = 1'b1;
        settle;
        chk(words.size(), 18);
        chk({words[0], words[1]}, 32'h0005_207f);
        // identifier outcomes: errors end the list, good ones stream
        for (int k = 0; k < 5; k++) begin
            words.delete();
            u_channel_model.list_q.delete();
            put('{16'h200b, 16'h0000});
            ids.push_back(id_a[k]);
            if (id_b[k] != 0) ids.push_back(id_b[k]);
            launch(16'h0100);
            settle;
            chk({adapter_status_word, 5'(words.size())}, {st_e[k], nw_e[k]});
            ids.delete();
        end
        conclude();
    end
endmodule : tb
